// ===== pkg/fbcfg_pkg.sv
package fbcfg_pkg;

    // Register addresses on the internal register port
    localparam logic [7:0] ADDR_FEEDBACK_SEL = 8'h04;
    localparam logic [7:0] ADDR_DROOP_FAULT = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h07;

    // Reset values
    localparam logic [7:0] RST_FEEDBACK_SEL = 8'h03;
    localparam logic [7:0] RST_DROOP_FAULT = 8'hE0;

    // Writable bit masks; all other bits are reserved
    localparam logic [7:0] WMASK_FEEDBACK_SEL = 8'h83;
    localparam logic [7:0] WMASK_DROOP_FAULT = 8'hEF;

    // Field positions
    localparam int FB_SEL_BIT = 7;
    localparam int SC_EN_BIT = 7;
    localparam int OC_EN_BIT = 6;
    localparam int OV_EN_BIT = 5;
    localparam int DROOP_SRC_BIT = 3;
    localparam int FLAG_SC_BIT = 7;
    localparam int FLAG_OC_BIT = 6;
    localparam int FLAG_OV_BIT = 5;

    // Internal divider ratio codes, in units of 1/10000
    localparam logic [1:0] RATIO_2256 = 2'h0;
    localparam logic [1:0] RATIO_1128 = 2'h1;
    localparam logic [1:0] RATIO_0752 = 2'h2;
    localparam logic [1:0] RATIO_0564 = 2'h3;

    // Droop rise step per code, in millivolts at the full sense differential
    localparam int DROOP_STEP_MV = 100;
    localparam int DROOP_SENSE_MV = 50;

    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Fault conditions from the power stage
    typedef struct packed {
        logic short_circuit;
        logic overcurrent;
        logic overvoltage;
    } fault_s;

endpackage

// ===== hdl/fault_flag_bit.sv
`timescale 1ns/1ps
// Sticky fault flag: set by condition, cleared by a status read; set wins
module fault_flag_bit (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cond,
    input wire logic i_clear,
    output logic o_flag
);
    logic flag_r;
    logic flag_nxt;

    // Condition still present at the read re-sets the flag at once
    assign flag_nxt = i_cond | (flag_r & ~i_clear);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign o_flag = flag_r;

    a_flag_sets: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond |=> flag_r) else $error("flag not set by condition");
endmodule // fault_flag_bit

// ===== hdl/feedback_and_droop_config_regs.sv
`timescale 1ns/1ps
module feedback_and_droop_config_regs
    import fbcfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire reg_req_s i_req,
    input wire fault_s i_fault,
    output logic [7:0] o_rdata,
    output logic o_fb_pin_out,
    output logic o_fb_pin_oe,
    output logic o_use_external_feedback,
    output logic [1:0] o_internal_divider_ratio,
    output logic o_droop_comp_source,
    output logic [2:0] o_cable_droop_comp_level,
    output logic [9:0] o_droop_rise_mv
);
    logic [7:0] fb_sel_r;
    logic [7:0] droop_r;
    logic [7:0] rdata_r;
    logic pin_out_r;
    logic pin_oe_r;
    logic [9:0] rise_r;
    logic flag_sc;
    logic flag_oc;
    logic flag_ov;

    // One address compare shared by the strobes, the read mux and the checks
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Address decode; unmapped addresses fall through and change nothing
    wire hit_fb = reg_hit(i_req.addr, ADDR_FEEDBACK_SEL);
    wire hit_droop = reg_hit(i_req.addr, ADDR_DROOP_FAULT);
    wire hit_status = reg_hit(i_req.addr, ADDR_STATUS);
    wire wr_fb = i_req.wr && hit_fb;
    wire wr_droop = i_req.wr && hit_droop;
    wire rd_status = i_req.rd && hit_status;

    // Only writable bits are stored, so reserved bits stay zero
    wire [7:0] fb_sel_nxt = wr_fb ? (i_req.wdata & WMASK_FEEDBACK_SEL) : fb_sel_r;
    wire [7:0] droop_nxt = wr_droop ? (i_req.wdata & WMASK_DROOP_FAULT) : droop_r;

    // Status view: the three sticky flags, other bits left zero here
    wire [7:0] status_view = {flag_sc, flag_oc, flag_ov, 5'h00};

    // Read mux registered from the address alone, so no read strobe is needed
    wire [7:0] rdata_nxt = hit_fb ? fb_sel_r :
                           hit_droop ? droop_r :
                           hit_status ? status_view : 8'h00;

    // Enabled fault indications
    wire any_fault = (flag_sc & droop_r[SC_EN_BIT]) | (flag_oc & droop_r[OC_EN_BIT])
                   | (flag_ov & droop_r[OV_EN_BIT]);

    // Pin is driven only in internal-feedback mode; external mode releases it
    wire pin_oe_nxt = ~fb_sel_nxt[FB_SEL_BIT];
    // Active-low indicator: low on an enabled fault flag, high otherwise
    wire pin_out_nxt = ~any_fault;

    // Droop rise applies only with internal compensation
    wire [9:0] rise_nxt = droop_nxt[DROOP_SRC_BIT] ? 10'h000 :
        10'(DROOP_STEP_MV) * {7'h00, droop_nxt[2:0]};

    // Per-flag sticky bits; a read in the set cycle keeps the flag
    fault_flag_bit u_sc (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cond(i_fault.short_circuit),
        .i_clear(rd_status),
        .o_flag(flag_sc)
    );
    fault_flag_bit u_oc (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cond(i_fault.overcurrent),
        .i_clear(rd_status),
        .o_flag(flag_oc)
    );
    fault_flag_bit u_ov (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cond(i_fault.overvoltage),
        .i_clear(rd_status),
        .o_flag(flag_ov)
    );

    // Configuration storage and registered outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fb_sel_r <= RST_FEEDBACK_SEL;
            droop_r <= RST_DROOP_FAULT;
            rdata_r <= 8'h00;
            pin_out_r <= 1'b1;
            pin_oe_r <= 1'b1;
            rise_r <= 10'h000;
        end else begin
            fb_sel_r <= fb_sel_nxt;
            droop_r <= droop_nxt;
            rdata_r <= rdata_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_fb_pin_out = pin_out_r;
    assign o_fb_pin_oe = pin_oe_r;
    assign o_use_external_feedback = fb_sel_r[FB_SEL_BIT];
    assign o_internal_divider_ratio = fb_sel_r[1:0];
    assign o_droop_comp_source = droop_r[DROOP_SRC_BIT];
    assign o_cable_droop_comp_level = droop_r[2:0];
    assign o_droop_rise_mv = rise_r;

    // Checks; every property samples on the system clock

    // Reset values land at the edge that sees reset
    a_fb_reset_value: assert property (@(posedge i_clk_sys)
        i_rst |=> (fb_sel_r == 8'h03)) else $error("feedback reg reset wrong");
    a_droop_reset_value: assert property (@(posedge i_clk_sys)
        i_rst |=> (droop_r == 8'hE0)) else $error("droop reg reset wrong");
    a_oe_after_reset: assert property (@(posedge i_clk_sys)
        i_rst |=> o_fb_pin_oe) else $error("pin not driven after reset");

    // Pin ownership follows the select bit in the same cycle
    a_pin_drive_internal: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !fb_sel_r[7] |-> o_fb_pin_oe) else $error("pin not driven internal");
    a_pin_release_ext: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        fb_sel_r[7] |-> !o_fb_pin_oe) else $error("pin driven in external");

    // Writes land one edge after the strobe; other cycles leave the value alone
    a_ratio_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_fb |=> (o_internal_divider_ratio == $past(i_req.wdata[1:0])))
        else $error("ratio not written");
    a_fb_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !wr_fb |=> $stable(fb_sel_r)) else $error("feedback reg changed unasked");
    a_ext_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_fb |=> (o_use_external_feedback == $past(i_req.wdata[7])))
        else $error("select bit not written");
    a_enables_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_droop |=> (droop_r[7:5] == $past(i_req.wdata[7:5])))
        else $error("enables not written");
    a_source_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_droop |=> (o_droop_comp_source == $past(i_req.wdata[3])))
        else $error("droop source not written");
    a_level_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_droop |=> (o_cable_droop_comp_level == $past(i_req.wdata[2:0])))
        else $error("droop level not written");
    a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (fb_sel_r[6:2] == 5'h00) && (droop_r[4] == 1'b0))
        else $error("reserved bit set");

    // Read-back is registered from the address presented one cycle earlier
    a_rdata_feedback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        hit_fb |=> (o_rdata == $past(fb_sel_r))) else $error("feedback read-back wrong");
    a_rdata_droop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        hit_droop |=> (o_rdata == $past(droop_r))) else $error("droop read-back wrong");
    a_rdata_status: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        hit_status |=> (o_rdata == {$past(flag_sc), $past(flag_oc), $past(flag_ov), 5'h00}))
        else $error("status read-back wrong");
    a_rdata_unmapped: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(hit_fb || hit_droop || hit_status) |=> (o_rdata == 8'h00))
        else $error("unmapped read not zero");

    // Fault indication is a two-step path: the condition sets the sticky flag,
    // and the registered pin follows the flag one edge later. A write to the
    // enables in the first step is left out, since it may mask the flag.
    sequence s_sc_raise;
        (i_fault.short_circuit && droop_r[SC_EN_BIT] && !wr_droop) ##1 flag_sc;
    endsequence
    sequence s_oc_raise;
        (i_fault.overcurrent && droop_r[OC_EN_BIT] && !wr_droop) ##1 flag_oc;
    endsequence
    sequence s_ov_raise;
        (i_fault.overvoltage && droop_r[OV_EN_BIT] && !wr_droop) ##1 flag_ov;
    endsequence
    // A status read with every condition gone drops all flags, then the pin returns high
    sequence s_clean_read;
        rd_status && !i_fault.short_circuit && !i_fault.overcurrent && !i_fault.overvoltage;
    endsequence

    a_sc_to_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_sc_raise |=> !o_fb_pin_out) else $error("short circuit not shown");
    a_oc_to_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_oc_raise |=> !o_fb_pin_out) else $error("overcurrent not shown");
    a_ov_to_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_ov_raise |=> !o_fb_pin_out) else $error("overvoltage not shown");
    a_clean_read_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_clean_read |=> ##1 o_fb_pin_out) else $error("pin low after clean read");
    a_masked_no_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (droop_r[7:5] == 3'h0) |=> o_fb_pin_out) else $error("pin low while masked");
    a_idle_pin_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!flag_sc && !flag_oc && !flag_ov) |=> o_fb_pin_out) else $error("pin low with no flag");
    a_fault_pin_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (flag_ov && droop_r[5]) |=> !o_fb_pin_out) else $error("enabled fault not shown");
    a_read_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rd_status && !i_fault.short_circuit) |=> !flag_sc) else $error("read not clearing");

    // Droop rise is computed from the next value, so a write in the checked
    // cycle is left out: the rise already shows the new setting
    a_ext_droop_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (droop_r[3] && !wr_droop) |=> (o_droop_rise_mv == 10'h000))
        else $error("rise in external mode");
    a_droop_level_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!droop_r[3] && !wr_droop) |=> (o_droop_rise_mv == 10'd100 * $past(droop_r[2:0])))
        else $error("rise level wrong");
endmodule // feedback_and_droop_config_regs

// ===== verification/fbcfg_host.sv
`timescale 1ns/1ps
// Host side of the register port; strobes launch at the falling edge
module fbcfg_host
    import fbcfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    output reg_req_s o_req
);
    initial o_req = '0;
    // Write held across one rising edge; stale data inverted so it never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk_sys);
        o_req.wr = 1'b0;
        o_req.wdata = ~d;
    endtask
    // Read data is registered from the address, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge i_clk_sys);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_clk_sys);
        o_req.rd = 1'b0;
        q = i_rdata;
    endtask
endmodule // fbcfg_host

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fbcfg_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    reg_req_s req;
    fault_s flt = '0;
    logic [7:0] rdata, q;
    logic pin_out, pin_oe, ext_fb, src;
    logic [1:0] ratio;
    logic [2:0] lvl;
    logic [9:0] rise;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    int m04 = 'h03, m05 = 'hE0, d; // Behavioural register images
    // Free-running system clock
    initial forever #2 i_clk_sys = ~i_clk_sys;
    feedback_and_droop_config_regs feedback_and_droop_config_regs_i (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_req(req), .i_fault(flt), .o_rdata(rdata), .o_fb_pin_out(pin_out),
        .o_fb_pin_oe(pin_oe), .o_use_external_feedback(ext_fb), .o_internal_divider_ratio(ratio),
        .o_droop_comp_source(src), .o_cable_droop_comp_level(lvl), .o_droop_rise_mv(rise));
    fbcfg_host fbcfg_host_i (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_req(req));
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Every configuration output and both read-backs against the model
    task automatic check_outputs();
        check(ext_fb, 10'(m04[7]));
        check(pin_oe, 10'(!m04[7]));
        check(ratio, 10'(m04[1:0]));
        check(src, 10'(m05[3]));
        check(rise, 10'(m05[3] ? 0 : 100 * m05[2:0]));
        check(lvl, 10'(m05[2:0]));
        fbcfg_host_i.rd(ADDR_FEEDBACK_SEL, q);
        check(q, 10'(m04[7:0]));
        fbcfg_host_i.rd(ADDR_DROOP_FAULT, q);
        check(q, 10'(m05[7:0]));
    endtask
    // Hang guard, sized well above the few hundred cycles the run needs
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h79369217));
        repeat (20) @(negedge i_clk_sys);
        i_rst = 1'b0;
        check(pin_out, 10'h001);
        check_outputs();
        // Every droop level with both sources, random data in reserved bits
        for (int k = 0; k < 16; k++) begin
            d = $urandom;
            fbcfg_host_i.wr(ADDR_DROOP_FAULT, {d[7:4], 4'(k)});
            m05 = {d[7:4], 4'(k)} & WMASK_DROOP_FAULT;
            fbcfg_host_i.wr(ADDR_FEEDBACK_SEL, d[15:8]);
            m04 = d[15:8] & WMASK_FEEDBACK_SEL;
            check_outputs();
        end
        fbcfg_host_i.wr(8'h06, 8'hFF); // Unmapped write must change nothing
        check_outputs();
        fbcfg_host_i.rd(8'h06, q);
        check(q, 10'h000);
        fbcfg_host_i.wr(ADDR_FEEDBACK_SEL, 8'h03);
        m04 = 'h03;
        // Each fault kind with its enable set, then cleared
        for (int k = 0; k < 6; k++) begin
            m05 = (k < 3) ? 'hE0 : ('hE0 ^ ('h80 >> (k % 3)));
            fbcfg_host_i.wr(ADDR_DROOP_FAULT, 8'(m05));
            @(negedge i_clk_sys);
            flt = 3'b100 >> (k % 3);
            repeat (2) @(negedge i_clk_sys);
            check(pin_out, 10'(k >= 3));
            flt = '0;
            fbcfg_host_i.rd(ADDR_STATUS, q);
            check(q, 10'(8'h80 >> (k % 3)));
            @(negedge i_clk_sys);
            check(pin_out, 10'h001);
            fbcfg_host_i.rd(ADDR_STATUS, q);
            check(q, 10'h000);
        end
        test_done();
    end
endmodule // tb_top
